/* core/vmcs_params.svh */
// constants for the video mode colour select block
// assumes inclusion by the package and by the vmcs_top design file
`ifndef VMCS_PARAMS_SVH
`define VMCS_PARAMS_SVH
`define VMCS_ADDR_CTRL_A 16'hd011
`define VMCS_ADDR_CTRL_B 16'hd016
`define VMCS_ADDR_BG0 16'hd021
`define VMCS_ADDR_BG1 16'hd022
`define VMCS_ADDR_BG2 16'hd023
`define VMCS_ADDR_BG3 16'hd024
`define VMCS_BIT_ECM 6
`define VMCS_BIT_BMM 5
`define VMCS_BIT_MCM 4
`define VMCS_REG_RST 8'h00
`define VMCS_RD_NONE 8'h00
`define VMCS_GLYPH_MASK 8'h3f
`define VMCS_LAST_DOT 3'h7
`define VMCS_FIFO_DEPTH 8
`define VMCS_CELL_W 20
`define VMCS_BG_SEL 7:6
`define VMCS_HI_NYB 7:4
`define VMCS_LO_NYB 3:0
`define VMCS_DOT_BIT 7
`define VMCS_PAIR_BITS 7:6
`endif

/* core/vmcs_pkg.sv */
// types shared by the video mode colour select design
// assumes vmcs_params.svh is on the include path
`include "vmcs_params.svh"
package vmcs_pkg;
  typedef enum logic [1:0] {
    vmcs_std_char = 2'b00,
    vmcs_ecm_char = 2'b01,
    vmcs_std_bmp = 2'b10,
    vmcs_mc_bmp = 2'b11
  } vmcs_mode_e;
  typedef logic [3:0] vmcs_color_t;
endpackage

/* core/vmcs_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module vmcs_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW:0] next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data = mem[rp];
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
      wp <= '0;
      rp <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      cnt <= next_cnt;
      wp <= push ? wp + 1'b1 : wp;
      rp <= pop ? rp + 1'b1 : rp;
      in_ready <= next_cnt != (AW+1)'(D);
      out_valid <= next_cnt != '0;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule // vmcs_fifo
`default_nettype wire

/* core/vmcs_top.sv */
// dot colour selection for character, extended background and bitmap modes
// assumes fetched cells arrive as code, colour nybble and pattern byte
`include "vmcs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module vmcs_top
  import vmcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  output logic [7:0] bus_rdata,
  input wire logic [7:0] code_in,
  output logic [7:0] glyph_code,
  input wire logic cell_valid,
  input wire logic [7:0] cell_code,
  input wire logic [3:0] cell_color,
  input wire logic [7:0] cell_pattern,
  output logic cell_ready,
  output logic pix_valid,
  output vmcs_color_t pix_color
);
  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic [7:0] bg [4];
  wire hit_a = bus_addr == `VMCS_ADDR_CTRL_A;
  wire hit_b = bus_addr == `VMCS_ADDR_CTRL_B;
  wire [3:0] hit_bg = {bus_addr == `VMCS_ADDR_BG3, bus_addr == `VMCS_ADDR_BG2,
                       bus_addr == `VMCS_ADDR_BG1, bus_addr == `VMCS_ADDR_BG0};
  wire ecm = ctrl_a[`VMCS_BIT_ECM];
  wire bmm = ctrl_a[`VMCS_BIT_BMM];
  wire mcm = ctrl_b[`VMCS_BIT_MCM];
  wire [7:0] next_rdata = hit_a ? ctrl_a :
                          hit_b ? ctrl_b :
                          hit_bg[0] ? bg[0] :
                          hit_bg[1] ? bg[1] :
                          hit_bg[2] ? bg[2] :
                          hit_bg[3] ? bg[3] : `VMCS_RD_NONE;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_a <= `VMCS_REG_RST;
      ctrl_b <= `VMCS_REG_RST;
    end else begin
      if (bus_we && hit_a) begin
        ctrl_a <= bus_wdata;
      end
      if (bus_we && hit_b) begin
        ctrl_b <= bus_wdata;
      end
    end
  end

  // one writable colour register per background slot
  for (genvar i = 0; i < 4; i++) begin : g_bg
    always_ff @(posedge clk) begin
      if (rst) begin
        bg[i] <= `VMCS_REG_RST;
      end else if (bus_we && hit_bg[i]) begin
        bg[i] <= bus_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_rdata <= `VMCS_RD_NONE;
    end else if (bus_re) begin
      bus_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // mode decode and glyph index
  // ---------------------------------------------------------------
  vmcs_mode_e mode;
  // bitmap takes priority over extended background
  assign mode = bmm ? (mcm ? vmcs_mc_bmp : vmcs_std_bmp)
                    : (ecm ? vmcs_ecm_char : vmcs_std_char);
  wire [7:0] next_glyph = (mode == vmcs_ecm_char) ? (code_in & `VMCS_GLYPH_MASK) : code_in;

  always_ff @(posedge clk) begin
    if (rst) begin
      glyph_code <= `VMCS_REG_RST;
    end else begin
      glyph_code <= next_glyph;
    end
  end

  // ---------------------------------------------------------------
  // cell buffer
  // ---------------------------------------------------------------
  logic f_valid;
  logic [`VMCS_CELL_W-1:0] f_data;
  logic pop;

  vmcs_fifo #(
    .W(`VMCS_CELL_W),
    .D(`VMCS_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(cell_valid),
    .in_data({cell_code, cell_color, cell_pattern}),
    .in_ready(cell_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(pop)
  );

  // ---------------------------------------------------------------
  // dot serializer
  // ---------------------------------------------------------------
  logic s_busy;
  logic [2:0] s_cnt;
  logic [7:0] s_code;
  logic [3:0] s_color;
  logic [7:0] s_pat;
  vmcs_mode_e s_mode;
  wire s_last = s_cnt == `VMCS_LAST_DOT;
  assign pop = f_valid && (!s_busy || s_last);
  wire mc_step = s_cnt[0];
  // multicolour dots are two bits wide, so the pair shifts every other dot
  wire [7:0] next_pat = (s_mode == vmcs_mc_bmp) ? (mc_step ? {s_pat[5:0], 2'b00} : s_pat)
                                                : {s_pat[6:0], 1'b0};

  always_ff @(posedge clk) begin
    if (rst) begin
      s_busy <= 1'b0;
      s_cnt <= '0;
      s_code <= '0;
      s_color <= '0;
      s_pat <= '0;
      s_mode <= vmcs_std_char;
    end else if (pop) begin
      {s_code, s_color, s_pat} <= f_data;
      s_cnt <= '0;
      s_busy <= 1'b1;
      s_mode <= mode;
    end else if (s_busy) begin
      s_cnt <= s_cnt + 3'h1;
      s_pat <= next_pat;
      s_busy <= !s_last;
    end
  end

  // ---------------------------------------------------------------
  // colour selection
  // ---------------------------------------------------------------
  wire dot = s_pat[`VMCS_DOT_BIT];
  wire [1:0] pair = s_pat[`VMCS_PAIR_BITS];
  wire [1:0] bg_sel = s_code[`VMCS_BG_SEL];
  // live register read, so a new background shows at the next dot
  wire [3:0] bg_pick = bg[bg_sel][`VMCS_LO_NYB];
  wire [3:0] bg0 = bg[0][`VMCS_LO_NYB];
  wire [3:0] hi_nyb = s_code[`VMCS_HI_NYB];
  wire [3:0] lo_nyb = s_code[`VMCS_LO_NYB];
  vmcs_color_t next_color;

  always_comb begin
    case (s_mode)
      vmcs_std_char: next_color = dot ? s_color : bg0;
      vmcs_ecm_char: next_color = dot ? s_color : bg_pick;
      vmcs_std_bmp: next_color = dot ? hi_nyb : lo_nyb;
      vmcs_mc_bmp: begin
        case (pair)
          2'b00: next_color = bg0;
          2'b01: next_color = hi_nyb;
          2'b10: next_color = lo_nyb;
          default: next_color = s_color;
        endcase
      end
      default: next_color = bg0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pix_valid <= 1'b0;
      pix_color <= '0;
    end else begin
      pix_valid <= s_busy;
      pix_color <= s_busy ? next_color : '0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_ecm_enable: assert property (bus_we && hit_a |=> ecm == $past(bus_wdata[6]))
    else $error("ecm bit not taken from write");
  a_bmp_enable: assert property (bus_we && hit_a |=> bmm == $past(bus_wdata[5]))
    else $error("bitmap bit not taken from write");
  a_mc_needs_both: assert property ((mode == vmcs_mc_bmp) == (bmm && mcm))
    else $error("multicolour bitmap without both bits");
  a_glyph_six_bits: assert property (mode == vmcs_ecm_char |=> glyph_code[7:6] == 2'b00)
    else $error("ecm glyph uses top code bits");
  a_ecm_background: assert property (s_busy && s_mode == vmcs_ecm_char && !dot
      |=> pix_color == $past(bg[s_code[7:6]][3:0]))
    else $error("wrong ecm background register");
  a_char_foreground: assert property (s_busy && !s_mode[1] && dot
      |=> pix_color == $past(s_color))
    else $error("foreground not from colour memory");
  a_bmp_set_dot: assert property (s_busy && s_mode == vmcs_std_bmp && dot
      |=> pix_color == $past(s_code[7:4]))
    else $error("set dot not upper nybble");
  a_bmp_clear_dot: assert property (s_busy && s_mode == vmcs_std_bmp && !dot
      |=> pix_color == $past(s_code[3:0]))
    else $error("clear dot not lower nybble");
  a_cell_eight_dots: assert property (pop && !s_busy |=> ##1 pix_valid [*8])
    else $error("cell did not give eight dots");
  a_mc_double_wide: assert property (s_busy && s_mode == vmcs_mc_bmp && !s_cnt[0]
      |=> ##1 $stable(pix_color))
    else $error("multicolour dot not two wide");
  // a background written mid-cell shows from the dot after the write
  a_bg_next_dot: assert property (bus_we && hit_bg[0] && s_busy |=> ##1 (!pix_valid
      || $past(s_mode) != vmcs_std_char || $past(dot)
      || pix_color == $past(bus_wdata[3:0], 2)))
    else $error("background change not seen");

  // ---------------------------------------------------------------
  // register, mode and stream checks
  // ---------------------------------------------------------------
  a_bg0_kept: assert property (bus_we && hit_bg[0] |=> bg[0] == $past(bus_wdata))
    else $error("background register 0 not stored");
  a_bg1_kept: assert property (bus_we && hit_bg[1] |=> bg[1] == $past(bus_wdata))
    else $error("background register 1 not stored");
  a_bg2_kept: assert property (bus_we && hit_bg[2] |=> bg[2] == $past(bus_wdata))
    else $error("background register 2 not stored");
  a_bg3_kept: assert property (bus_we && hit_bg[3] |=> bg[3] == $past(bus_wdata))
    else $error("background register 3 not stored");
  a_mc_bit_taken: assert property (bus_we && hit_b |=> mcm == $past(bus_wdata[4]))
    else $error("multicolour bit not taken from write");
  a_glyph_whole: assert property (mode != vmcs_ecm_char
      |=> glyph_code == $past(code_in))
    else $error("glyph code altered outside ecm");
  a_rdata_hold: assert property (!bus_re |=> $stable(bus_rdata))
    else $error("read data changed without a read");
  a_bitmap_wins: assert property (bmm
      |-> (mode == vmcs_std_bmp || mode == vmcs_mc_bmp))
    else $error("bitmap bit did not select a bitmap mode");
  a_ecm_mode: assert property (ecm && !bmm |-> mode == vmcs_ecm_char)
    else $error("ecm bit did not select ecm mode");
  a_mode_latched: assert property (s_busy && !pop |=> $stable(s_mode))
    else $error("mode changed inside a cell");
  a_cell_ends: assert property (s_busy && s_last && !pop |=> ##1 !pix_valid)
    else $error("cell gave more than eight dots");
  a_idle_zero: assert property (!pix_valid |-> pix_color == '0)
    else $error("colour shown without a dot");

  // ---------------------------------------------------------------
  // dot colour checks
  // ---------------------------------------------------------------
  a_std_char_bg: assert property (s_busy && s_mode == vmcs_std_char && !dot
      |=> pix_color == $past(bg[0][3:0]))
    else $error("standard background not register 0");
  a_mc_pair_bg: assert property (s_busy && s_mode == vmcs_mc_bmp && pair == 2'b00
      |=> pix_color == $past(bg[0][3:0]))
    else $error("multicolour pair 00 not background 0");
  a_mc_pair_hi: assert property (s_busy && s_mode == vmcs_mc_bmp && pair == 2'b01
      |=> pix_color == $past(s_code[7:4]))
    else $error("multicolour pair 01 not upper nybble");
  a_mc_pair_lo: assert property (s_busy && s_mode == vmcs_mc_bmp && pair == 2'b10
      |=> pix_color == $past(s_code[3:0]))
    else $error("multicolour pair 10 not lower nybble");
  a_mc_pair_mem: assert property (s_busy && s_mode == vmcs_mc_bmp && pair == 2'b11
      |=> pix_color == $past(s_color))
    else $error("multicolour pair 11 not colour nybble");

  // ---------------------------------------------------------------
  // cover points
  // ---------------------------------------------------------------
  c_ecm_cell: cover property (pop && mode == vmcs_ecm_char);
  c_mc_bitmap: cover property (pop && mode == vmcs_mc_bmp);
  c_fifo_full: cover property (!cell_ready ##1 cell_valid);
  c_std_bitmap: cover property (pop && mode == vmcs_std_bmp);
  c_bg_live_change: cover property (bus_we && hit_bg[0] && s_busy && s_mode == vmcs_std_char);
endmodule // vmcs_top
`default_nettype wire

/* verification/vmcs_cell_src.sv */
// cell source standing in for the fetch side of the dot stream
// assumes offer is called just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module vmcs_cell_src (
  input wire logic clk,
  input wire logic cell_ready,
  output logic cell_valid,
  output logic [7:0] cell_code,
  output logic [3:0] cell_color,
  output logic [7:0] cell_pattern
);
  logic r;
  initial begin
    cell_valid = 1'b0;
    cell_code = 8'h00;
    cell_color = 4'h0;
    cell_pattern = 8'h00;
  end
  // hold the cell until taken; a released line shows inverted data
  task automatic offer(input logic [7:0] c, input logic [3:0] k, input logic [7:0] p,
                       input logic last);
    cell_valid = 1'b1;
    cell_code = c;
    cell_color = k;
    cell_pattern = p;
    do begin
      @(negedge clk);
      r = cell_ready;
      @(posedge clk);
    end while (r !== 1'b1);
    #1;
    if (last) begin
      cell_valid = 1'b0;
      cell_code = ~c;
      cell_color = ~k;
      cell_pattern = ~p;
    end
  endtask
endmodule // vmcs_cell_src
`default_nettype wire

/* verification/video_mode_color_select_tb.sv */
// self-checking bench for the dot colour select block
// assumes the core files and the cell source model are compiled first
`timescale 1ns/1ps
`default_nettype none
module video_mode_color_select_tb
  import vmcs_pkg::*;
;
  logic clk, rst, bus_we, bus_re, cell_valid, cell_ready, pix_valid, saw_full;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, code_in, glyph_code, cell_code, cell_pattern, ctl, cb, c, p;
  logic [3:0] cell_color, k;
  logic [7:0] w;
  vmcs_color_t pix_color;
  logic [7:0] bg [4];
  logic [22:0] e;
  logic [22:0] q [$];
  int miscompares, checked, seed, cyc;
  logic [15:0] regs [6] = '{16'hd011, 16'hd016, 16'hd021, 16'hd022, 16'hd023, 16'hd024};
  logic [7:0] ctls [6] = '{8'h00, 8'h40, 8'h20, 8'h20, 8'h60, 8'h00};
  logic [7:0] cbs [6] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h10};

  vmcs_top u_dut (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata), .code_in(code_in),
    .glyph_code(glyph_code), .cell_valid(cell_valid), .cell_code(cell_code),
    .cell_color(cell_color), .cell_pattern(cell_pattern), .cell_ready(cell_ready),
    .pix_valid(pix_valid), .pix_color(pix_color));
  vmcs_cell_src u_src (.clk(clk), .cell_ready(cell_ready), .cell_valid(cell_valid),
    .cell_code(cell_code), .cell_color(cell_color), .cell_pattern(cell_pattern));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [3:0] dot_exp(input logic [22:0] x);
    logic [7:0] dc, dp;
    logic [3:0] dk;
    logic [2:0] i;
    logic [1:0] pr;
    dc = x[22:15];
    dk = x[14:11];
    dp = x[10:3];
    i = x[2:0];
    pr = {dp[7-(i&3'h6)], dp[6-(i&3'h6)]};
    if (ctl[5] && cb[4])
      return (pr == 2'h0) ? bg[0][3:0] : (pr == 2'h1) ? dc[7:4] : (pr == 2'h2) ? dc[3:0] : dk;
    if (ctl[5])
      return dp[7-i] ? dc[7:4] : dc[3:0];
    if (ctl[6])
      return dp[7-i] ? dk : bg[dc[7:6]][3:0];
    return dp[7-i] ? dk : bg[0][3:0];
  endfunction
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    bus_addr = a;
    bus_wdata = d;
    bus_we = 1'b1;
    @(posedge clk);
    #1;
    bus_we = 1'b0;
    bus_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] x);
    @(posedge clk);
    #1;
    bus_addr = a;
    bus_re = 1'b1;
    @(posedge clk);
    #1;
    bus_re = 1'b0;
    chk(bus_rdata, x);
  endtask
  // ----------------------------------------
  // dot monitor and timeout
  // ----------------------------------------
  always @(negedge clk) begin
    if (!rst) begin
      if (cell_ready === 1'b0)
        saw_full = 1'b1;
      if (pix_valid === 1'b1 && q.size() > 0) begin
        e = q.pop_front();
        chk(8'(pix_color), 8'(dot_exp(e)));
      end else begin
        chk(8'(pix_valid), 8'h00);
        chk(8'(pix_color), 8'h00);
      end
    end
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 28;
    miscompares = 0;
    checked = 0;
    cyc = 0;
    rst = 1'b1;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_we = 1'b0;
    bus_re = 1'b0;
    code_in = 8'h00;
    saw_full = 1'b0;
    ctl = 8'h00;
    cb = 8'h00;
    bg = '{default: 8'h00};
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(8'(cell_ready), 8'h01);
    for (int i = 0; i < 6; i++) rd(regs[i], 8'h00);
    wr(16'hd025, 8'hff);
    rd(16'hd025, 8'h00);
    for (int m = 0; m < 6; m++) begin
      ctl = ctls[m];
      cb = cbs[m];
      wr(16'hd011, ctl);
      wr(16'hd016, cb);
      for (int j = 0; j < 4; j++) begin
        bg[j] = 8'($random(seed));
        wr(regs[2+j], bg[j]);
      end
      rd(regs[2+(m%4)], bg[m%4]);
      @(posedge clk);
      #1;
      code_in = 8'($random(seed));
      @(posedge clk);
      #1;
      chk(glyph_code, (ctl[6] && !ctl[5]) ? (code_in & 8'h3f) : code_in);
      for (int n = 0; n < 12; n++) begin
        c = (n < 4) ? {n[1:0], 6'h01} : 8'($random(seed));
        k = 4'($random(seed));
        p = (n == 4) ? 8'hff : (n == 5) ? 8'h00 : 8'($random(seed));
        for (int i = 0; i < 8; i++) q.push_back({c, k, p, 3'(i)});
        u_src.offer(c, k, p, m[0] || n == 11);
        if (m[0]) repeat (3) @(posedge clk);
        if (m[0]) #1;
      end
      if (m == 0) begin
        w = 8'($random(seed));
        wr(16'hd021, w);
        @(posedge clk);
        #1;
        bg[0] = w;
      end
      repeat (150) @(posedge clk);
      #1;
      chk(8'(q.size()), 8'h00);
    end
    chk(8'(saw_full), 8'h01);
    tally_and_finish;
  end
endmodule // video_mode_color_select_tb
`default_nettype wire
